// ===== core/fault_status_pkg.sv
// Constants, register map, field layout and helpers of the supply fault/status capture block.
// Assumes the fault plane, status and record bytes use the per-input bit layout below.
package fault_status_pkg;

    // Channel index of each monitored input in the channel vectors
    localparam int CH_N   = 8;
    localparam int CH_VP1 = 0;
    localparam int CH_VP2 = 1;
    localparam int CH_VP3 = 2;
    localparam int CH_VH  = 3;
    localparam int CH_VX1 = 4;
    localparam int CH_VX2 = 5;
    localparam int CH_VX3 = 6;
    localparam int CH_VX4 = 7;
    localparam int AUX_N  = 4;

    // Register offsets on the host read port
    localparam logic [7:0] ADDR_FP_LOW   = 8'hE0;
    localparam logic [7:0] ADDR_FP_HIGH  = 8'hE1;
    localparam logic [7:0] ADDR_OV_LOW   = 8'hE2;
    localparam logic [7:0] ADDR_OV_HIGH  = 8'hE3;
    localparam logic [7:0] ADDR_UV_LOW   = 8'hE4;
    localparam logic [7:0] ADDR_UV_HIGH  = 8'hE5;
    localparam logic [7:0] ADDR_LIM_LOW  = 8'hE6;
    localparam logic [7:0] ADDR_LIM_HIGH = 8'hE7;
    localparam logic [7:0] ADDR_AUX_LVL  = 8'hE8;
    localparam logic [7:0] ADDR_CAUSE    = 8'hEA;
    localparam logic [7:0] ADDR_PREV     = 8'hEB;
    localparam logic [7:0] ADDR_SNAP1    = 8'hEC;
    localparam logic [7:0] ADDR_SNAP2    = 8'hED;
    localparam logic [7:0] ADDR_SNAP3    = 8'hEE;
    localparam logic [7:0] ADDR_SNAP4    = 8'hEF;
    localparam logic [7:0] ADDR_SNAP5    = 8'hF0;
    localparam logic [7:0] BYTE_ZERO     = 8'h00;

    // Record layout in EEPROM
    localparam logic [15:0] REC_BASE     = 16'hF980;
    localparam int          REC_BYTES    = 8;
    localparam int          REC_SHIFT    = 3;
    localparam int          SNAP_BYTES   = 7;
    localparam logic [2:0]  REC_LAST     = 3'h7;
    localparam logic [2:0]  REC_CK_IDX   = 3'h7;
    localparam int          USED_BIT     = 7;
    localparam int          STATE_W      = 6;
    localparam int          CAUSE_W      = 6;

    typedef enum logic {CK_NEG_SUM = 1'b0, CK_XOR = 1'b1} checksum_mode_e;
    typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_SEND = 2'b10} wr_state_e;

    // Low byte of the per-input layout
    function automatic logic [7:0] map_low(input logic [CH_N-1:0] ch);
        return {ch[CH_VX2], ch[CH_VX1], 1'b0, ch[CH_VH],
                ch[CH_VP3], ch[CH_VP2], ch[CH_VP1], 1'b0};
    endfunction : map_low

    // High byte of the per-input layout
    function automatic logic [7:0] map_high(input logic [CH_N-1:0] ch);
        return {6'h00, ch[CH_VX4], ch[CH_VX3]};
    endfunction : map_high

    // Integrity byte over the seven record bytes as written
    function automatic logic [7:0] bb_checksum(input checksum_mode_e mode,
                                               input logic [8*SNAP_BYTES-1:0] b);
        logic [7:0] acc;
        acc = BYTE_ZERO;
        for (int i = 0; i < SNAP_BYTES; i++) begin
            acc = (mode == CK_XOR) ? (acc ^ b[8*i +: 8]) : 8'(acc + b[8*i +: 8]);
        end
        return (mode == CK_XOR) ? acc : 8'(~acc + 8'h01);
    endfunction : bb_checksum

endpackage : fault_status_pkg

// ===== core/record_if.sv
// Carrier between the capture block and its record writer.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface record_if;
    logic        start;
    logic [55:0] bytes;
    logic [15:0] base;
    logic        busy;
    modport ctrl   (output start, output bytes, output base, input busy);
    modport writer (input start, input bytes, input base, output busy);
endinterface : record_if

// ===== core/record_writer.sv
// Writes one eight-byte fault record to EEPROM: seven snapshot bytes then a checksum.
// Assumes the EEPROM side pulses i_ee_ack once per held write request.
`timescale 1ns/1ps
module record_writer
    import fault_status_pkg::*;
#(
    parameter checksum_mode_e CK_MODE = CK_NEG_SUM
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rstn,
    record_if.writer         rec,
    input  wire logic        i_ee_ack,
    output logic             o_ee_wr,
    output logic [15:0]      o_ee_addr,
    output logic [7:0]       o_ee_data
);
    wr_state_e   state,   next_state;
    logic [2:0]  idx,     next_idx;
    logic [55:0] buf_q,   next_buf;
    logic        next_wr;
    logic [15:0] next_addr;
    logic [7:0]  next_data;

    assign rec.busy = (state == WR_SEND);

    always_comb begin
        next_state = state;
        next_idx   = idx;
        next_buf   = buf_q;
        next_wr    = o_ee_wr;
        next_addr  = o_ee_addr;
        next_data  = o_ee_data;
        case (state)
            WR_IDLE: begin
                if (rec.start) begin
                    next_buf           = rec.bytes;
                    next_buf[USED_BIT] = 1'b1;
                    next_state         = WR_SEND;
                    next_idx           = 3'h0;
                    next_wr            = 1'b1;
                    next_addr          = rec.base;
                    next_data          = next_buf[7:0];
                end
            end
            WR_SEND: begin
                if (i_ee_ack) begin
                    if (idx == REC_LAST) begin
                        next_state = WR_IDLE;
                        next_wr    = 1'b0;
                    end else begin
                        next_idx  = 3'(idx + 3'h1);
                        next_addr = 16'(o_ee_addr + 16'h0001);
                        next_data = (next_idx == REC_CK_IDX)
                                  ? bb_checksum(CK_MODE, buf_q)
                                  : buf_q[8*next_idx +: 8];
                    end
                end
            end
            default: begin
                next_state = WR_IDLE;
                next_wr    = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            state     <= WR_IDLE;
            idx       <= 3'h0;
            buf_q     <= 56'h0;
            o_ee_wr   <= 1'b0;
            o_ee_addr <= 16'h0000;
            o_ee_data <= 8'h00;
        end else begin
            state     <= next_state;
            idx       <= next_idx;
            buf_q     <= next_buf;
            o_ee_wr   <= next_wr;
            o_ee_addr <= next_addr;
            o_ee_data <= next_data;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_start;
        rec.start && state == WR_IDLE;
    endsequence
    property p_first_byte;
        s_start |=> o_ee_wr && o_ee_addr == $past(rec.base) && o_ee_data[USED_BIT];
    endproperty
    a_first_byte: assert property (p_first_byte) else $error("record first byte wrong");
    property p_step;
        o_ee_wr && i_ee_ack && idx != REC_LAST
            |=> o_ee_wr && o_ee_addr == $past(o_ee_addr) + 16'h0001;
    endproperty
    a_step: assert property (p_step) else $error("record address did not step");
    property p_hold;
        o_ee_wr && !i_ee_ack |=> o_ee_wr && $stable(o_ee_addr) && $stable(o_ee_data);
    endproperty
    a_hold: assert property (p_hold) else $error("write request dropped");
    property p_checksum;
        o_ee_wr && idx == REC_CK_IDX |-> o_ee_data == bb_checksum(CK_MODE, buf_q);
    endproperty
    a_checksum: assert property (p_checksum) else $error("checksum byte wrong");
endmodule : record_writer

// ===== core/supply_fault_status_capture.sv
// Fault plane, live status registers and black box snapshot with EEPROM records.
// Assumes the sequencer, ADC limit logic and EEPROM port share i_ref_clk;
// detector and aux pin levels are asynchronous and synchronised here.
`timescale 1ns/1ps
module supply_fault_status_capture
    import fault_status_pkg::*;
#(
    parameter int             NUM_REC = 16,
    parameter checksum_mode_e CK_MODE = CK_NEG_SUM
) (
    input  wire logic               i_ref_clk,
    input  wire logic               i_rstn,
    input  wire logic [CH_N-1:0]    i_fault_sfd,
    input  wire logic [CH_N-1:0]    i_ov_sfd,
    input  wire logic [CH_N-1:0]    i_uv_sfd,
    input  wire logic [AUX_N-1:0]   i_ov_warn,
    input  wire logic [AUX_N-1:0]   i_uv_warn,
    input  wire logic [AUX_N-1:0]   i_aux_level,
    input  wire logic [AUX_N-1:0]   i_aux_digital,
    input  wire logic [CH_N-1:0]    i_adc_over,
    input  wire logic               i_state_change,
    input  wire logic [STATE_W-1:0] i_prev_state,
    input  wire logic [CAUSE_W-1:0] i_cause,
    input  wire logic               i_fault_wr_en,
    input  wire logic               i_rec_trigger,
    input  wire logic               i_reg_rd,
    input  wire logic [7:0]         i_reg_addr,
    output logic [7:0]              o_reg_rdata,
    output logic                    o_reg_rvalid,
    input  wire logic [NUM_REC-1:0] i_rec_used,
    input  wire logic               i_ee_ack,
    output logic                    o_ee_wr,
    output logic [15:0]             o_ee_addr,
    output logic [7:0]              o_ee_data,
    output logic                    o_rec_busy,
    output logic                    o_rec_full
);
    localparam int SYNC_W = 3 * CH_N + 3 * AUX_N;
    localparam int SLOT_W = (NUM_REC > 1) ? $clog2(NUM_REC) : 1;

    // Three-stage synchroniser; a change counts once stages two and three agree
    logic [SYNC_W-1:0] sync1, sync2, sync3, filt;
    logic [SYNC_W-1:0] next_filt;

    always_comb begin
        next_filt = (~(sync2 ^ sync3) & sync2) | ((sync2 ^ sync3) & filt);
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            filt  <= '0;
        end else begin
            sync1 <= {i_aux_level, i_uv_warn, i_ov_warn, i_uv_sfd, i_ov_sfd, i_fault_sfd};
            sync2 <= sync1;
            sync3 <= sync2;
            filt  <= next_filt;
        end
    end

    logic [CH_N-1:0]  f_sfd, f_ov, f_uv;
    logic [AUX_N-1:0] f_ovw, f_uvw, f_lvl;
    assign {f_lvl, f_uvw, f_ovw, f_uv, f_ov, f_sfd} = filt;

    // Per-input live conditions with the digital aux substitution
    logic [CH_N-1:0] fp_live, ov_live, uv_live;

    always_comb begin
        fp_live = f_sfd;
        ov_live = f_ov;
        uv_live = f_uv;
        for (int k = 0; k < AUX_N; k++) begin
            if (i_aux_digital[k]) begin
                fp_live[CH_VX1 + k] = f_lvl[k];
                ov_live[CH_VX1 + k] = f_ovw[k];
                uv_live[CH_VX1 + k] = f_uvw[k];
            end
        end
    end

    // Live status registers and the gated fault plane
    logic [7:0] fp_low, fp_high, ov_low, ov_high, uv_low, uv_high;
    logic [7:0] lim_low, lim_high, aux_stat;
    logic [7:0] next_fp_low, next_fp_high, next_aux_stat;

    always_comb begin
        next_fp_low   = fp_low;
        next_fp_high  = fp_high;
        if (i_fault_wr_en) begin
            next_fp_low  = map_low(fp_live);
            next_fp_high = map_high(fp_live);
        end
        next_aux_stat = {3'h0, f_lvl, 1'b0};
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            fp_low   <= BYTE_ZERO;
            fp_high  <= BYTE_ZERO;
            ov_low   <= BYTE_ZERO;
            ov_high  <= BYTE_ZERO;
            uv_low   <= BYTE_ZERO;
            uv_high  <= BYTE_ZERO;
            lim_low  <= BYTE_ZERO;
            lim_high <= BYTE_ZERO;
            aux_stat <= BYTE_ZERO;
        end else begin
            fp_low   <= next_fp_low;
            fp_high  <= next_fp_high;
            ov_low   <= map_low(ov_live);
            ov_high  <= map_high(ov_live);
            uv_low   <= map_low(uv_live);
            uv_high  <= map_high(uv_live);
            lim_low  <= map_low(i_adc_over);
            lim_high <= map_high(i_adc_over);
            aux_stat <= next_aux_stat;
        end
    end

    // Black box snapshot, free-record search and record start
    logic [CAUSE_W-1:0] bb_cause, next_bb_cause;
    logic [STATE_W-1:0] bb_prev, next_bb_prev;
    logic [39:0]        bb_stat, next_bb_stat;
    logic [NUM_REC-1:0] used_loc, next_used_loc, all_used;
    logic [SLOT_W-1:0]  slot;
    logic               found;
    logic               rec_start, next_rec_start;
    logic [15:0]        rec_base, next_rec_base;
    logic               next_rec_busy;
    record_if           rec ();

    assign all_used = i_rec_used | used_loc;

    always_comb begin
        found = 1'b0;
        slot  = '0;
        for (int i = NUM_REC - 1; i >= 0; i--) begin
            if (!all_used[i]) begin
                found = 1'b1;
                slot  = SLOT_W'(i);
            end
        end
    end

    always_comb begin
        next_bb_cause  = bb_cause;
        next_bb_prev   = bb_prev;
        next_bb_stat   = bb_stat;
        next_used_loc  = used_loc;
        next_rec_base  = rec_base;
        next_rec_start = 1'b0;
        if (i_state_change) begin
            next_bb_cause = i_cause;
            next_bb_prev  = i_prev_state;
            next_bb_stat  = {aux_stat,
                             lim_high[1:0], ov_high[1:0], uv_high[1:0], 2'b00,
                             lim_low, ov_low, uv_low};
            if (i_rec_trigger && found && !rec.busy && !rec_start) begin
                next_rec_start      = 1'b1;
                next_used_loc[slot] = 1'b1;
                next_rec_base       = 16'(REC_BASE + (16'(slot) << REC_SHIFT));
            end
        end
        next_rec_busy = rec.busy | next_rec_start;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            bb_cause   <= '0;
            bb_prev    <= '0;
            bb_stat    <= '0;
            used_loc   <= '0;
            rec_base   <= REC_BASE;
            rec_start  <= 1'b0;
            o_rec_busy <= 1'b0;
            o_rec_full <= 1'b0;
        end else begin
            bb_cause   <= next_bb_cause;
            bb_prev    <= next_bb_prev;
            bb_stat    <= next_bb_stat;
            used_loc   <= next_used_loc;
            rec_base   <= next_rec_base;
            rec_start  <= next_rec_start;
            o_rec_busy <= next_rec_busy;
            o_rec_full <= ~found;
        end
    end

    assign rec.start = rec_start;
    assign rec.base  = rec_base;
    assign rec.bytes = {bb_stat, 2'b00, bb_prev, 2'b00, bb_cause};

    record_writer #(
        .CK_MODE (CK_MODE)
    ) u_writer (
        .i_ref_clk (i_ref_clk),
        .i_rstn    (i_rstn),
        .rec       (rec.writer),
        .i_ee_ack  (i_ee_ack),
        .o_ee_wr   (o_ee_wr),
        .o_ee_addr (o_ee_addr),
        .o_ee_data (o_ee_data)
    );

    // Host register read port; one-cycle answer, unmapped offsets read zero
    logic [7:0] next_rdata;

    always_comb begin
        case (i_reg_addr)
            ADDR_FP_LOW:   next_rdata = fp_low;
            ADDR_FP_HIGH:  next_rdata = fp_high;
            ADDR_OV_LOW:   next_rdata = ov_low;
            ADDR_OV_HIGH:  next_rdata = ov_high;
            ADDR_UV_LOW:   next_rdata = uv_low;
            ADDR_UV_HIGH:  next_rdata = uv_high;
            ADDR_LIM_LOW:  next_rdata = lim_low;
            ADDR_LIM_HIGH: next_rdata = lim_high;
            ADDR_AUX_LVL:  next_rdata = aux_stat;
            ADDR_CAUSE:    next_rdata = {2'b00, bb_cause};
            ADDR_PREV:     next_rdata = {2'b00, bb_prev};
            ADDR_SNAP1:    next_rdata = bb_stat[7:0];
            ADDR_SNAP2:    next_rdata = bb_stat[15:8];
            ADDR_SNAP3:    next_rdata = bb_stat[23:16];
            ADDR_SNAP4:    next_rdata = bb_stat[31:24];
            ADDR_SNAP5:    next_rdata = bb_stat[39:32];
            default:       next_rdata = BYTE_ZERO;
        endcase
        if (!i_reg_rd) begin
            next_rdata = o_reg_rdata;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_reg_rdata  <= BYTE_ZERO;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rdata  <= next_rdata;
            o_reg_rvalid <= i_reg_rd;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    property p_fp_freeze;
        !i_fault_wr_en |=> $stable(fp_low) && $stable(fp_high);
    endproperty
    a_fp_freeze: assert property (p_fp_freeze) else $error("fault plane moved while frozen");
    property p_fp_track;
        i_fault_wr_en |=> fp_low == map_low($past(fp_live)) && fp_high == map_high($past(fp_live));
    endproperty
    a_fp_track: assert property (p_fp_track) else $error("fault plane not tracking input");
    property p_layout;
        fp_low[5] == 1'b0 && fp_low[0] == 1'b0 && fp_high[7:2] == 6'h00
            && aux_stat[0] == 1'b0 && aux_stat[7:5] == 3'h0;
    endproperty
    a_layout: assert property (p_layout) else $error("unused plane or aux bit set");
    property p_ov_digital;
        i_aux_digital[0] |=> ov_low[6] == $past(f_ovw[0]);
    endproperty
    a_ov_digital: assert property (p_ov_digital) else $error("digital aux lacks warning");
    property p_snap;
        i_state_change |=> bb_prev == $past(i_prev_state) && bb_cause == $past(i_cause)
            && bb_stat[7:0] == $past(uv_low);
    endproperty
    a_snap: assert property (p_snap) else $error("snapshot not taken on state change");
    sequence s_trig;
        i_state_change && i_rec_trigger && found && !rec.busy && !rec_start;
    endsequence
    property p_rec_start;
        s_trig |=> rec_start && o_rec_busy ##1 o_ee_wr && o_ee_addr[2:0] == 3'h0;
    endproperty
    a_rec_start: assert property (p_rec_start) else $error("record write did not start");
    property p_claim;
        s_trig |=> used_loc != $past(used_loc);
    endproperty
    a_claim: assert property (p_claim) else $error("record slot not claimed");
    property p_read;
        i_reg_rd && i_reg_addr == ADDR_CAUSE |=> o_reg_rvalid && o_reg_rdata[7:6] == 2'b00
            && o_reg_rdata[5:0] == $past(bb_cause);
    endproperty
    a_read: assert property (p_read) else $error("cause byte read wrong");
    property p_unmapped;
        i_reg_rd && i_reg_addr == 8'hFF |=> o_reg_rvalid && o_reg_rdata == BYTE_ZERO;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : supply_fault_status_capture

// ===== verification/ee_model.sv
// EEPROM responder: acknowledges each held write request after a set delay.
// Assumes the writer holds its request until the acknowledge pulse.
`timescale 1ns/1ps
module ee_model (
    input  wire logic       i_ref_clk,
    input  wire logic       i_ee_wr,
    input  wire logic [1:0] i_delay,
    output logic            o_ee_ack
);
    logic [1:0] cnt;
    initial begin
        o_ee_ack = 1'b0;
        cnt = 2'h0;
    end
    // One pulse per byte; no acknowledge in the cycle after a pulse
    always @(posedge i_ref_clk) begin
        o_ee_ack <= 1'b0;
        if (i_ee_wr && !o_ee_ack) begin
            cnt <= (cnt == i_delay) ? 2'h0 : cnt + 2'h1;
            o_ee_ack <= (cnt == i_delay);
        end
    end
endmodule : ee_model

// ===== verification/supply_fault_status_capture_tb.sv
// Self-checking bench for the supply fault and status capture block.
// Assumes the EEPROM responder model answers every write request.
`timescale 1ns/1ps
module supply_fault_status_capture_tb;
    import fault_status_pkg::*;
    logic        i_ref_clk, i_rstn, sc, wen, trg, rd, ack, wr, rv, busy, full;
    logic [7:0]  flt, ov, uv, adc, ad, rdat, ed;
    logic [3:0]  ovw, uvw, lvl, dig;
    logic [5:0]  prv, cau;
    logic [15:0] used, ea;
    logic [1:0]  dly;
    int          bad_count, n_checks, cyc;
    supply_fault_status_capture i_dut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
        .i_fault_sfd(flt), .i_ov_sfd(ov), .i_uv_sfd(uv), .i_ov_warn(ovw), .i_uv_warn(uvw),
        .i_aux_level(lvl), .i_aux_digital(dig), .i_adc_over(adc), .i_state_change(sc),
        .i_prev_state(prv), .i_cause(cau), .i_fault_wr_en(wen), .i_rec_trigger(trg),
        .i_reg_rd(rd), .i_reg_addr(ad), .o_reg_rdata(rdat), .o_reg_rvalid(rv),
        .i_rec_used(used), .i_ee_ack(ack), .o_ee_wr(wr), .o_ee_addr(ea), .o_ee_data(ed),
        .o_rec_busy(busy), .o_rec_full(full));
    ee_model i_ee (.i_ref_clk(i_ref_clk), .i_ee_wr(wr), .i_delay(dly), .o_ee_ack(ack));
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_ref_clk);
        rd <= 1'b1;
        ad <= a;
        @(posedge i_ref_clk);
        rd <= 1'b0;
        #1 cmp({7'h00, rv, rdat}, {8'h01, e});
    endtask : rdc
    // Apply plane inputs, then let the synchronisers settle
    task automatic settle(input logic [7:0] f, input logic w, input logic [3:0] d);
        @(posedge i_ref_clk);
        flt <= f;
        wen <= w;
        dig <= d;
        repeat (8) @(posedge i_ref_clk);
    endtask : settle
    task automatic t_plane();
        for (int i = 0; i < 9; i++) rdc(ADDR_FP_LOW + 8'(i), (i == 8) ? 8'h0A : 8'h00);
        rdc(8'hFF, 8'h00);
        settle(8'hFF, 1'b1, 4'h0);
        rdc(ADDR_FP_LOW, 8'hDE);
        rdc(ADDR_FP_HIGH, 8'h03);
        settle(8'h00, 1'b0, 4'h0);
        rdc(ADDR_FP_LOW, 8'hDE);
        settle(8'h00, 1'b1, 4'h0);
        rdc(ADDR_FP_LOW, 8'h00);
        settle(8'h00, 1'b1, 4'hF);
        rdc(ADDR_FP_LOW, 8'h40);
        rdc(ADDR_FP_HIGH, 8'h01);
        $display("plane test done");
    endtask : t_plane
    task automatic t_status();
        logic [7:0] exp [7] = '{8'h1E, 8'h00, 8'hDE, 8'h03, 8'hC0, 8'h03, 8'h0A};
        @(posedge i_ref_clk);
        ov <= 8'h0F;
        uv <= 8'hFF;
        adc <= 8'hF0;
        ovw <= 4'h1;
        uvw <= 4'h2;
        settle(8'h00, 1'b0, 4'hF);
        rdc(ADDR_OV_LOW, 8'h5E);
        rdc(ADDR_UV_LOW, 8'h9E);
        settle(8'h00, 1'b0, 4'h0);
        for (int i = 0; i < 7; i++) rdc(ADDR_OV_LOW + 8'(i), exp[i]);
        $display("status test done");
    endtask : t_status
    task automatic t_record();
        logic [7:0] exp [8] = '{8'h84, 8'h2A, 8'hDE, 8'h1E, 8'hC0, 8'hCC, 8'h0A, 8'hC0};
        int n;
        @(posedge i_ref_clk);
        sc <= 1'b1;
        prv <= 6'h2A;
        cau <= 6'h04;
        trg <= 1'b1;
        @(posedge i_ref_clk);
        sc <= 1'b0;
        trg <= 1'b0;
        #1 cmp(16'(busy), 16'h0001);
        for (int i = 0; i < 8; i++) begin
            dly = 2'(i);
            @(posedge i_ref_clk);
            #1 n = 0;
            while (ack !== 1'b1 && n < 20) begin
                @(posedge i_ref_clk);
                #1 n++;
            end
            cmp(ea, 16'hF988 + 16'(i));
            cmp(16'(ed), 16'(exp[i]));
        end
        repeat (3) @(posedge i_ref_clk);
        #1 cmp(16'({wr, busy}), 16'h0000);
        rdc(ADDR_CAUSE, 8'h04);
        for (int i = 1; i < 7; i++) rdc(ADDR_CAUSE + 8'(i), exp[i]);
        cmp(16'(full), 16'h0000);
        // Claim every remaining slot: full rises and a trigger is dropped
        @(posedge i_ref_clk);
        used <= 16'hFFFD;
        repeat (2) @(posedge i_ref_clk);
        #1 cmp(16'(full), 16'h0001);
        @(posedge i_ref_clk);
        sc <= 1'b1;
        trg <= 1'b1;
        @(posedge i_ref_clk);
        sc <= 1'b0;
        trg <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        #1 cmp(16'({wr, busy}), 16'h0000);
        $display("record test done");
    endtask : t_record
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run
    initial begin
        i_ref_clk = 1'b0;
        forever #10 i_ref_clk = ~i_ref_clk;
    end
    // Ceiling well above the few hundred cycles the tests need
    always @(posedge i_ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        {i_rstn, sc, wen, trg, rd, flt, ov, uv, adc, ad, ovw, uvw, dig, prv, cau, dly} = '0;
        lvl = 4'h5;
        used = 16'h0001;
        bad_count = 0;
        n_checks = 0;
        cyc = 0;
        repeat (12) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        t_plane();
        t_status();
        t_record();
        complete_run();
    end
endmodule : supply_fault_status_capture_tb
